/* rtl/crf_top.sv */
// Dual-mode CPU register file: banks, index, pointers, page base, refresh and mode flags
// Function
// [RL1] Compatibility mode: pairs one to three and index registers act as 16 bits.
// [RL2] Compatibility mode uses the 16-bit short stack pointer for stack work.
// [RL3] Compatibility program counter is 16 bits; addresses are page base over 16 bits.
// [RL4] Page base writes are blocked in compatibility mode.
// [RL5] Upper bytes are undefined in compatibility mode and not kept defined.
// [RL6] Compatibility mode ignores the interrupt page upper byte.
// [RL7] Long mode: pairs one to three and index registers act as 24 bits.
// [RL8] Long multibyte register is upper, high, low byte concatenated.
// [RL9] No upper byte is addressable as a standalone byte register.
// [RL10] Long mode ignores page base for addresses but accepts its writes.
// [RL11] Long mode: 24-bit program counter and long stack pointer active.
// [RL12] Accumulators, flags, working bytes and pair upper bytes have no reset.
// [RL13] Reset clears interrupt page, index bytes, page base and refresh counter.
// [RL14] Reset clears program counter and both stack pointers.
// [RL15] Mode, mixed and interrupt enable flags are single bits; all four reset to 0.
// [RL16] Flag 0 means compatibility mode, flag 1 means long linear mode.
// [RL17] Compatibility stack address is page base above short stack pointer.
// [RL18] Active stack pointer and program counter width follow the flag combinationally.
`timescale 1ns/1ns
`default_nettype none
`include "crf_params.svh"
module crf_top (
  input  wire logic                ref_clk,
  input  wire logic                reset,
  input  wire crf_pkg::crf_addr_t  reg_addr,
  input  wire crf_pkg::crf_long_t  reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [23:0]              reg_rdata_q,
  input  wire logic                pc_inc,
  input  wire logic                fetch_done,
  input  wire logic                mode_load,
  input  wire logic                mode_value,
  input  wire logic [2:0]          ind_sel,
  output logic                     long_mode_q,
  output logic                     mixed_mode_q,
  output logic                     interrupt_enable_flag_one_q,
  output logic                     interrupt_enable_flag_two_q,
  output logic [23:0]              pc_addr_q,
  output logic [23:0]              sp_addr_q,
  output logic [23:0]              ind_addr_q,
  output logic [15:0]              int_page_q
);
  import crf_pkg::*;

  crf_mode_t mode_q;
  logic      mixed_mode_flag_q;
  logic      ie1_q;
  logic      ie2_q;
  crf_word_t ipage_q;
  crf_byte_t memory_page_base_q;
  crf_byte_t refresh_q;
  crf_long_t idx_q [0:1];
  crf_long_t pc_q;
  crf_word_t sps_q;
  crf_long_t spl_q;
  crf_byte_t bank_bytes [0:1][0:7];
  crf_long_t bank_pairs [0:1][0:2];
  crf_long_t pc_addr_w;
  crf_long_t sp_addr_w;
  crf_long_t ind_addr_w;
  crf_long_t ind_val_w;
  crf_long_t rd_mux;

  // Equal-address decode shared by all write enables except the bank byte and pair ranges
  function automatic logic hit(input crf_addr_t a, input crf_addr_t code);
    hit = (a == code);
  endfunction : hit

  // Long mode keeps 24 bits, compatibility shows the low 16 with the upper byte as zero
  function automatic crf_long_t mode_fit(input logic lng, input crf_long_t v);
    mode_fit = lng ? v : {`CRF_RST_BYTE, v[15:0]};
  endfunction : mode_fit

  // Mode decode
  wire long_w      = (mode_q == CRF_MODE_LONG);
  wire we_memory_page_base    = reg_wr && hit(reg_addr, `CRF_A_MEMORY_PAGE_BASE) && long_w;
  wire we_ipage_lo = reg_wr && hit(reg_addr, `CRF_A_IPAGE_LO);
  wire we_ipage_hi = reg_wr && hit(reg_addr, `CRF_A_IPAGE_HI);
  wire we_refresh  = reg_wr && hit(reg_addr, `CRF_A_REFRESH);
  wire we_flags    = reg_wr && hit(reg_addr, `CRF_A_MODEFLAGS);
  wire we_sp       = reg_wr && hit(reg_addr, `CRF_A_SP);
  wire we_pc       = reg_wr && hit(reg_addr, `CRF_A_PC);
  // Bank byte and pair decode; no index reaches an upper byte alone [RL9]
  wire we_bank_any = reg_wr && (reg_addr <= `CRF_A_BANK_END);
  wire we_pair     = reg_wr && (reg_addr >= `CRF_A_PAIR1) && (reg_addr <= `CRF_A_PAIR3);
  wire [1:0] pair_sel = 2'(reg_addr - `CRF_A_PAIR1);

  // Main and alternate banks
  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_bank
      crf_bank u_bank (
        .ref_clk   (ref_clk),
        .byte_we   (we_bank_any && (reg_addr[3] == 1'(b))),
        .byte_idx  (reg_addr[2:0]),
        .pair_we   (we_pair && (b == 0)),
        .pair_idx  (pair_sel),
        .long_mode (long_w),
        .wdata     (reg_wdata),
        .byte_out  (bank_bytes[b]),
        .pair_out  (bank_pairs[b])
      );
    end
  endgenerate

  // Index registers clear at reset; upper byte written only in long mode [RL13] [RL1] [RL7] [RL8]
  genvar x;
  generate
    for (x = 0; x < 2; x++) begin : g_idx
      wire we_hi   = reg_wr && hit(reg_addr, 5'(`CRF_A_IDX0_HI + 2 * x));
      wire we_lo   = reg_wr && hit(reg_addr, 5'(`CRF_A_IDX0_LO + 2 * x));
      wire we_full = reg_wr && hit(reg_addr, 5'(`CRF_A_IDX0 + x));
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          idx_q[x] <= `CRF_RST_LONG;
        end else if (we_full) begin
          idx_q[x] <= long_w ? reg_wdata : {idx_q[x][23:16], reg_wdata[15:0]};
        end else if (we_hi) begin
          idx_q[x][15:8] <= reg_wdata[7:0];
        end else if (we_lo) begin
          idx_q[x][7:0] <= reg_wdata[7:0];
        end
      end
    end
  endgenerate

  // Mode flag moves only on a mode load, never on a register write [RL15] [RL16]
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_q <= CRF_MODE_COMPAT;
    end else if (mode_load) begin
      mode_q <= mode_value ? CRF_MODE_LONG : CRF_MODE_COMPAT;
    end
  end

  // Mixed mode and interrupt enable bits [RL15]
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mixed_mode_flag_q <= `CRF_RST_BIT;
      ie1_q  <= `CRF_RST_BIT;
      ie2_q  <= `CRF_RST_BIT;
    end else if (we_flags) begin
      mixed_mode_flag_q <= reg_wdata[`CRF_F_MIXED];
      ie1_q  <= reg_wdata[`CRF_F_INTERRUPT_ENABLE_FLAG_ONE];
      ie2_q  <= reg_wdata[`CRF_F_INTERRUPT_ENABLE_FLAG_TWO];
    end
  end

  // Page base takes writes in long mode only [RL4] [RL10] [RL13]
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      memory_page_base_q <= `CRF_RST_BYTE;
    end else if (we_memory_page_base) begin
      memory_page_base_q <= reg_wdata[7:0];
    end
  end

  // Interrupt page, both bytes writable [RL13]
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ipage_q <= `CRF_RST_WORD;
    end else if (we_ipage_lo) begin
      ipage_q[7:0] <= reg_wdata[7:0];
    end else if (we_ipage_hi) begin
      ipage_q[15:8] <= reg_wdata[7:0];
    end
  end

  // Refresh: low seven bits count fetches, top bit changes only by a write [RL13]
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      refresh_q <= `CRF_RST_BYTE;
    end else if (we_refresh) begin
      refresh_q <= reg_wdata[7:0];
    end else if (fetch_done) begin
      refresh_q[`CRF_R_CNT_MSB:0] <= refresh_q[`CRF_R_CNT_MSB:0] + `CRF_R_STEP;
    end
  end

  // Program counter: 16-bit wrap in compatibility, 24-bit in long mode [RL3] [RL11] [RL14]
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pc_q <= `CRF_RST_LONG;
    end else if (we_pc) begin
      pc_q <= long_w ? reg_wdata : {pc_q[23:16], reg_wdata[15:0]};
    end else if (pc_inc) begin
      pc_q <= long_w ? pc_q + `CRF_PC_STEP24 : {pc_q[23:16], pc_q[15:0] + `CRF_PC_STEP16};
    end
  end

  // Stack pointer writes land in the active one only [RL2] [RL11] [RL14]
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sps_q <= `CRF_RST_WORD;
      spl_q <= `CRF_RST_LONG;
    end else if (we_sp && long_w) begin
      spl_q <= reg_wdata;
    end else if (we_sp) begin
      sps_q <= reg_wdata[15:0];
    end
  end

  // Indirect operand select: 0..2 pairs, 3 and 4 index registers
  assign ind_val_w = (ind_sel == 3'h3) ? idx_q[0] :
                     (ind_sel == 3'h4) ? idx_q[1] :
                     (ind_sel <  3'h3) ? bank_pairs[0][ind_sel[1:0]] : `CRF_RST_LONG;

  crf_addr u_addr (
    .long_mode (long_w),
    .memory_page_base     (memory_page_base_q),
    .pc        (pc_q),
    .short_stack_pointer       (sps_q),
    .long_stack_pointer       (spl_q),
    .ind_val   (ind_val_w),
    .pc_addr   (pc_addr_w),
    .sp_addr   (sp_addr_w),
    .ind_addr  (ind_addr_w)
  );

  // Read selection; multibyte reads hide the upper byte in compatibility [RL5] [RL6]
  function automatic crf_long_t read_sel(input crf_addr_t a);
    read_sel = `CRF_RST_LONG;
    if (a <= `CRF_A_BANK_END) begin
      read_sel = {16'h0000, bank_bytes[a[3]][a[2:0]]};
    end else if (a >= `CRF_A_PAIR1 && a <= `CRF_A_PAIR3) begin
      read_sel = mode_fit(long_w, bank_pairs[0][2'(a - `CRF_A_PAIR1)]);
    end else begin
      unique case (a)
        `CRF_A_IPAGE_LO:  read_sel = {16'h0000, ipage_q[7:0]};
        `CRF_A_IPAGE_HI:  read_sel = {16'h0000, long_w ? ipage_q[15:8] : `CRF_RST_BYTE};
        `CRF_A_MEMORY_PAGE_BASE:     read_sel = {16'h0000, memory_page_base_q};
        `CRF_A_REFRESH:   read_sel = {16'h0000, refresh_q};
        `CRF_A_IDX0_HI:   read_sel = {16'h0000, idx_q[0][15:8]};
        `CRF_A_IDX0_LO:   read_sel = {16'h0000, idx_q[0][7:0]};
        `CRF_A_IDX1_HI:   read_sel = {16'h0000, idx_q[1][15:8]};
        `CRF_A_IDX1_LO:   read_sel = {16'h0000, idx_q[1][7:0]};
        `CRF_A_MODEFLAGS: read_sel = {20'h00000, long_w, ie2_q, ie1_q, mixed_mode_flag_q};
        `CRF_A_IDX0:      read_sel = mode_fit(long_w, idx_q[0]);
        `CRF_A_IDX1:      read_sel = mode_fit(long_w, idx_q[1]);
        `CRF_A_SP:        read_sel = long_w ? spl_q : {`CRF_RST_BYTE, sps_q};
        `CRF_A_PC:        read_sel = mode_fit(long_w, pc_q);
        default:          read_sel = `CRF_RST_LONG;
      endcase
    end
  endfunction : read_sel

  // Process form, so the select follows every register that the function reads
  always_comb rd_mux = read_sel(reg_addr);

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= `CRF_RST_LONG;
    end else begin
      reg_rdata_q <= reg_rd ? rd_mux : `CRF_RST_LONG;
    end
  end

  // Registered copies of flags, addresses and interrupt page [RL6] [RL18]
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      long_mode_q  <= `CRF_RST_BIT;
      mixed_mode_q <= `CRF_RST_BIT;
      interrupt_enable_flag_one_q       <= `CRF_RST_BIT;
      interrupt_enable_flag_two_q       <= `CRF_RST_BIT;
      pc_addr_q    <= `CRF_RST_LONG;
      sp_addr_q    <= `CRF_RST_LONG;
      ind_addr_q   <= `CRF_RST_LONG;
      int_page_q   <= `CRF_RST_WORD;
    end else begin
      long_mode_q  <= long_w;
      mixed_mode_q <= mixed_mode_flag_q;
      interrupt_enable_flag_one_q       <= ie1_q;
      interrupt_enable_flag_two_q       <= ie2_q;
      pc_addr_q    <= pc_addr_w;
      sp_addr_q    <= sp_addr_w;
      ind_addr_q   <= ind_addr_w;
      int_page_q   <= long_w ? ipage_q : {`CRF_RST_BYTE, ipage_q[7:0]};
    end
  end

  // Marks the first edge after reset release for the reset checks
  logic post_rst_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      post_rst_q <= 1'b0;
    end else begin
      post_rst_q <= 1'b1;
    end
  end

  // Checks
  property p_memory_page_base_block;
    @(posedge ref_clk) disable iff (reset)
      (reg_wr && hit(reg_addr, `CRF_A_MEMORY_PAGE_BASE) && !long_w) |=> $stable(memory_page_base_q);
  endproperty
  a_memory_page_base_block: assert property (p_memory_page_base_block) else $error("page base changed in compatibility"); // [RL4]

  property p_memory_page_base_long;
    @(posedge ref_clk) disable iff (reset)
      (reg_wr && hit(reg_addr, `CRF_A_MEMORY_PAGE_BASE) && long_w) |=> (memory_page_base_q == $past(reg_wdata[7:0]));
  endproperty
  a_memory_page_base_long: assert property (p_memory_page_base_long) else $error("page base write lost in long mode"); // [RL10]

  property p_compat_pc;
    @(posedge ref_clk) disable iff (reset)
      !long_w |=> (pc_addr_q == {$past(memory_page_base_q), $past(pc_q[15:0])});
  endproperty
  a_compat_pc: assert property (p_compat_pc) else $error("compat program address wrong"); // [RL3]

  property p_long_addr;
    @(posedge ref_clk) disable iff (reset)
      long_w |=> (pc_addr_q == $past(pc_q)) && (sp_addr_q == $past(spl_q));
  endproperty
  a_long_addr: assert property (p_long_addr) else $error("long mode address wrong"); // [RL11]

  property p_compat_sp;
    @(posedge ref_clk) disable iff (reset)
      !long_w |=> (sp_addr_q == {$past(memory_page_base_q), $past(sps_q)});
  endproperty
  a_compat_sp: assert property (p_compat_sp) else $error("compat stack address wrong"); // [RL17]

  property p_compat_pair_read;
    @(posedge ref_clk) disable iff (reset)
      (reg_rd && !long_w && reg_addr >= `CRF_A_PAIR1 && reg_addr <= `CRF_A_IDX1) |=> (reg_rdata_q[23:16] == 8'h00);
  endproperty
  a_compat_pair_read: assert property (p_compat_pair_read) else $error("compat read shows upper byte"); // [RL1]

  property p_long_pair_round;
    @(posedge ref_clk) disable iff (reset)
      (reg_wr && long_w && hit(reg_addr, `CRF_A_PAIR1) && !mode_load) ##1 (reg_rd && hit(reg_addr, `CRF_A_PAIR1))
        |=> (reg_rdata_q == $past(reg_wdata, 2));
  endproperty
  a_long_pair_round: assert property (p_long_pair_round) else $error("long pair lost bytes"); // [RL8]

  property p_reset_values;
    @(posedge ref_clk) disable iff (reset)
      !post_rst_q |-> (pc_q == 24'h000000) && (sps_q == 16'h0000) && (spl_q == 24'h000000)
        && (memory_page_base_q == 8'h00) && (idx_q[0] == 24'h000000) && (idx_q[1] == 24'h000000) && (refresh_q == 8'h00);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset value wrong"); // [RL14]

  property p_mode_hold;
    @(posedge ref_clk) disable iff (reset)
      !mode_load |=> $stable(mode_q);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode flag moved without load"); // [RL16]

  property p_ipage_compat;
    @(posedge ref_clk) disable iff (reset)
      !long_w |=> (int_page_q == {8'h00, $past(ipage_q[7:0])});
  endproperty
  a_ipage_compat: assert property (p_ipage_compat) else $error("interrupt page upper byte used"); // [RL6]

  property p_compat_sp_write;
    @(posedge ref_clk) disable iff (reset)
      (we_sp && !long_w) |=> $stable(spl_q) && (sps_q == $past(reg_wdata[15:0]));
  endproperty
  a_compat_sp_write: assert property (p_compat_sp_write) else $error("compat stack write wrong"); // [RL2]

  c_mode_switch: cover property (@(posedge ref_clk) disable iff (reset) !long_w ##1 long_w);
  c_memory_page_base_write: cover property (@(posedge ref_clk) disable iff (reset) we_memory_page_base);
  c_compat_pc_inc: cover property (@(posedge ref_clk) disable iff (reset) pc_inc && !long_w);
endmodule : crf_top
`default_nettype wire

/* rtl/crf_params.svh */
// Constants of the dual-mode CPU register file: register indices, bit positions and reset values
`ifndef CRF_PARAMS_SVH
`define CRF_PARAMS_SVH

// Register port indices, main and alternate working sets
`define CRF_A_ACC        5'h00
`define CRF_A_FLG        5'h01
`define CRF_A_BANK_END   5'h0F
// Interrupt page, page base, refresh, index bytes and mode flags
`define CRF_A_IPAGE_LO   5'h10
`define CRF_A_IPAGE_HI   5'h11
`define CRF_A_MEMORY_PAGE_BASE      5'h12
`define CRF_A_REFRESH    5'h13
`define CRF_A_IDX0_HI    5'h14
`define CRF_A_IDX0_LO    5'h15
`define CRF_A_IDX1_HI    5'h16
`define CRF_A_IDX1_LO    5'h17
`define CRF_A_MODEFLAGS  5'h18
// Multibyte registers, width follows the mode
`define CRF_A_PAIR1      5'h19
`define CRF_A_PAIR2      5'h1A
`define CRF_A_PAIR3      5'h1B
`define CRF_A_IDX0       5'h1C
`define CRF_A_IDX1       5'h1D
`define CRF_A_SP         5'h1E
`define CRF_A_PC         5'h1F

// Byte slots inside a working bank
`define CRF_B_PAIR_BASE  3'h2

// Mode flag register bit positions
`define CRF_F_MIXED      0
`define CRF_F_INTERRUPT_ENABLE_FLAG_ONE       1
`define CRF_F_INTERRUPT_ENABLE_FLAG_TWO       2
`define CRF_F_LONG       3

// Field limits
`define CRF_R_CNT_MSB    6
`define CRF_R_STEP       7'h01
`define CRF_PC_STEP16    16'h0001
`define CRF_PC_STEP24    24'h000001

// Reset values
`define CRF_RST_BYTE     8'h00
`define CRF_RST_WORD     16'h0000
`define CRF_RST_LONG     24'h000000
`define CRF_RST_BIT      1'b0

`endif

/* rtl/crf_pkg.sv */
// Types shared by the dual-mode CPU register file
package crf_pkg;
  typedef logic [7:0]  crf_byte_t;
  typedef logic [15:0] crf_word_t;
  typedef logic [23:0] crf_long_t;
  typedef logic [4:0]  crf_addr_t;
  typedef logic [2:0]  crf_slot_t;
  typedef enum logic { CRF_MODE_COMPAT, CRF_MODE_LONG } crf_mode_t;
endpackage : crf_pkg

/* rtl/crf_bank.sv */
// One working register bank: accumulator, flags, six byte registers and three upper bytes
`timescale 1ns/1ns
`default_nettype none
`include "crf_params.svh"
module crf_bank (
  input  wire logic                 ref_clk,
  input  wire logic                 byte_we,
  input  wire crf_pkg::crf_slot_t   byte_idx,
  input  wire logic                 pair_we,
  input  wire logic [1:0]           pair_idx,
  input  wire logic                 long_mode,
  input  wire crf_pkg::crf_long_t   wdata,
  output var  crf_pkg::crf_byte_t   byte_out [0:7],
  output var  crf_pkg::crf_long_t   pair_out [0:2]
);
  import crf_pkg::*;

  crf_byte_t regs_q  [0:7];
  crf_byte_t upper_q [0:2];

  // Slot of the high byte of a pair
  function automatic crf_slot_t hi_slot(input logic [1:0] p);
    hi_slot = `CRF_B_PAIR_BASE + {p, 1'b0};
  endfunction : hi_slot

  // Working bytes carry no reset, their start value is undefined [RL12]
  always_ff @(posedge ref_clk) begin
    if (byte_we) begin
      regs_q[byte_idx] <= wdata[7:0];
    end else if (pair_we) begin
      regs_q[hi_slot(pair_idx)]        <= wdata[15:8];
      regs_q[hi_slot(pair_idx) | 3'h1] <= wdata[7:0];
    end
  end

  // Upper byte is written only in long mode, compatibility leaves it as is [RL5] [RL7]
  always_ff @(posedge ref_clk) begin
    if (pair_we && long_mode) begin
      upper_q[pair_idx] <= wdata[23:16];
    end
  end

  // Pairs are upper, high and low byte in that order [RL8]
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_byte
      assign byte_out[g] = regs_q[g];
    end
    for (g = 0; g < 3; g++) begin : g_pair
      assign pair_out[g] = {upper_q[g], regs_q[`CRF_B_PAIR_BASE + 2 * g], regs_q[`CRF_B_PAIR_BASE + 2 * g + 1]};
    end
  endgenerate
endmodule : crf_bank
`default_nettype wire

/* rtl/crf_addr.sv */
// Address former: active stack pointer and 24-bit addresses for both memory modes
`timescale 1ns/1ns
`default_nettype none
module crf_addr (
  input  wire logic               long_mode,
  input  wire crf_pkg::crf_byte_t memory_page_base,
  input  wire crf_pkg::crf_long_t pc,
  input  wire crf_pkg::crf_word_t short_stack_pointer,
  input  wire crf_pkg::crf_long_t long_stack_pointer,
  input  wire crf_pkg::crf_long_t ind_val,
  output var  crf_pkg::crf_long_t pc_addr,
  output var  crf_pkg::crf_long_t sp_addr,
  output var  crf_pkg::crf_long_t ind_addr
);
  import crf_pkg::*;

  // Compatibility prefixes the page base, long mode is linear [RL3] [RL10] [RL16]
  assign pc_addr  = long_mode ? pc : {memory_page_base, pc[15:0]};
  // Stack pointer choice follows the flag with no storage [RL17] [RL18] [RL11] [RL2]
  assign sp_addr  = long_mode ? long_stack_pointer : {memory_page_base, short_stack_pointer};
  // Indirect operand: 16 bits under the page base or full 24 bits [RL1] [RL7]
  assign ind_addr = long_mode ? ind_val : {memory_page_base, ind_val[15:0]};
endmodule : crf_addr
`default_nettype wire

/* verification/crf_exec_model.sv */
// Execution-side model: drives the register port, the control pulses and the operand select
`timescale 1ns/1ns
`default_nettype none
module crf_exec_model (
  input  wire logic               ref_clk,
  input  wire crf_pkg::crf_long_t reg_rdata_q,
  output var  crf_pkg::crf_addr_t reg_addr,
  output var  crf_pkg::crf_long_t reg_wdata,
  output var  logic               reg_wr,
  output var  logic               reg_rd,
  output var  logic               pc_inc,
  output var  logic               fetch_done,
  output var  logic               mode_load,
  output var  logic               mode_value,
  output var  logic [2:0]         ind_sel
);
  import crf_pkg::*;
  // Everything idle from time zero
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, ind_sel} = '0;
    {pc_inc, fetch_done, mode_load, mode_value} = '0;
  end
  // One-cycle write strobe beside address and data
  task automatic wr(input crf_addr_t a, input crf_long_t d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // One-cycle read strobe; data stand only in the following cycle
  task automatic rd(input crf_addr_t a, output crf_long_t d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata_q;
  endtask : rd
  // Write then read of the same index on consecutive strobes
  task automatic wr_rd(input crf_addr_t a, input crf_long_t d, output crf_long_t q);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    q = reg_rdata_q;
  endtask : wr_rd
  // Pulse: 0 program counter step, 1 fetch done, 2 mode load with value v
  task automatic pulse(input logic [1:0] sel, input logic v);
    @(posedge ref_clk);
    pc_inc     <= (sel == 2'h0);
    fetch_done <= (sel == 2'h1);
    mode_load  <= (sel == 2'h2);
    mode_value <= v;
    @(posedge ref_clk);
    pc_inc     <= 1'b0;
    fetch_done <= 1'b0;
    mode_load  <= 1'b0;
  endtask : pulse
  // Operand select for indirect addressing
  task automatic ind(input logic [2:0] v);
    @(posedge ref_clk);
    ind_sel <= v;
  endtask : ind
endmodule : crf_exec_model
`default_nettype wire

/* verification/test_cpu_register_file_dual_mode.sv */
// Self-checking bench of the dual-mode register file with its execution-side model
`timescale 1ns/1ns
`default_nettype none
module test_cpu_register_file_dual_mode;
  import crf_pkg::*;
  logic               ref_clk;
  logic               reset;
  crf_addr_t          reg_addr;
  crf_long_t          reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [23:0]        reg_rdata_q;
  logic               pc_inc;
  logic               fetch_done;
  logic               mode_load;
  logic               mode_value;
  logic [2:0]         ind_sel;
  logic               long_mode_q;
  logic               mixed_mode_q;
  logic               interrupt_enable_flag_one_q;
  logic               interrupt_enable_flag_two_q;
  logic [23:0]        pc_addr_q;
  logic [23:0]        sp_addr_q;
  logic [23:0]        ind_addr_q;
  logic [15:0]        int_page_q;
  crf_long_t          got;
  int                 errors;
  int                 n_compared;
  // Rows: op (0 read and compare, 1 write, 2 mode load), index, data or expected value
  logic [30:0]        rows [0:28] = '{
    {2'h0, 5'h1F, 24'h000000}, {2'h0, 5'h1E, 24'h000000}, {2'h0, 5'h12, 24'h000000},
    {2'h0, 5'h13, 24'h000000}, {2'h0, 5'h1C, 24'h000000}, {2'h0, 5'h1D, 24'h000000},
    {2'h0, 5'h10, 24'h000000}, {2'h0, 5'h11, 24'h000000}, {2'h0, 5'h18, 24'h000000},
    {2'h2, 5'h00, 24'h000001}, {2'h0, 5'h18, 24'h000008}, {2'h1, 5'h12, 24'h0000AB},
    {2'h0, 5'h12, 24'h0000AB}, {2'h1, 5'h19, 24'h123456}, {2'h0, 5'h19, 24'h123456},
    {2'h1, 5'h02, 24'h000011}, {2'h1, 5'h03, 24'h000022}, {2'h0, 5'h19, 24'h121122},
    {2'h1, 5'h1C, 24'h789ABC}, {2'h0, 5'h14, 24'h00009A}, {2'h0, 5'h15, 24'h0000BC},
    {2'h1, 5'h18, 24'h000007}, {2'h0, 5'h18, 24'h00000F}, {2'h1, 5'h1F, 24'h34FFFF},
    {2'h1, 5'h1E, 24'hABCDEF}, {2'h0, 5'h1E, 24'hABCDEF}, {2'h1, 5'h11, 24'h00005A},
    {2'h1, 5'h10, 24'h0000A5}, {2'h0, 5'h11, 24'h00005A}};

  crf_exec_model u_exec (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .pc_inc(pc_inc), .fetch_done(fetch_done), .mode_load(mode_load),
    .mode_value(mode_value), .ind_sel(ind_sel), .reg_rdata_q(reg_rdata_q));
  crf_top dut_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .pc_inc(pc_inc), .fetch_done(fetch_done),
    .mode_load(mode_load), .mode_value(mode_value), .ind_sel(ind_sel), .long_mode_q(long_mode_q),
    .mixed_mode_q(mixed_mode_q), .interrupt_enable_flag_one_q(interrupt_enable_flag_one_q), .interrupt_enable_flag_two_q(interrupt_enable_flag_two_q), .pc_addr_q(pc_addr_q),
    .sp_addr_q(sp_addr_q), .ind_addr_q(ind_addr_q), .int_page_q(int_page_q));

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  // Compare, count and report at once
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Let a state change reach the registered outputs
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle
  task automatic results;
    $display("Compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // Hang guard
  initial begin
    repeat (4000) @(posedge ref_clk);
    errors++;
    $display("Error watchdog expected finish seen hang");
    results;
  end

  // Main sequence: reset, row table, then mode-crossing cases
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    errors = 0;
    n_compared = 0;
    repeat (7) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("pc_addr in reset", 24'h000000, pc_addr_q);
    chk("flags in reset", 24'h000000, {20'h0, long_mode_q, interrupt_enable_flag_two_q, interrupt_enable_flag_one_q, mixed_mode_q});
    @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 29; i++) begin
      case (rows[i][30:29])
        2'h0: begin
          u_exec.rd(rows[i][28:24], got);
          chk("read", rows[i][23:0], got);
        end
        2'h1: u_exec.wr(rows[i][28:24], rows[i][23:0]);
        default: begin
          u_exec.pulse(2'h2, rows[i][0]);
          settle;
        end
      endcase
    end
    u_exec.ind(3'h3);
    settle;
    chk("pc_addr long", 24'h34FFFF, pc_addr_q);
    chk("sp_addr long", 24'hABCDEF, sp_addr_q);
    chk("ind_addr long", 24'h789ABC, ind_addr_q);
    chk("int_page long", 24'h005AA5, {8'h00, int_page_q});
    chk("flags", 24'h00000F, {20'h0, long_mode_q, interrupt_enable_flag_two_q, interrupt_enable_flag_one_q, mixed_mode_q});
    u_exec.pulse(2'h2, 1'b0);
    settle;
    chk("pc_addr compat", 24'hABFFFF, pc_addr_q);
    chk("sp_addr compat", 24'hAB0000, sp_addr_q);
    chk("ind_addr compat", 24'hAB9ABC, ind_addr_q);
    chk("int_page compat", 24'h0000A5, {8'h00, int_page_q});
    u_exec.wr(5'h12, 24'h000077);
    u_exec.rd(5'h12, got);
    chk("page base", 24'h0000AB, got);
    u_exec.rd(5'h11, got);
    chk("ipage hi", 24'h000000, got);
    u_exec.rd(5'h19, got);
    chk("pair1 low", 24'h001122, {8'h00, got[15:0]});
    u_exec.wr(5'h1E, 24'h001234);
    settle;
    chk("sp_addr short", 24'hAB1234, sp_addr_q);
    u_exec.pulse(2'h0, 1'b0);
    settle;
    chk("pc wrap", 24'hAB0000, pc_addr_q);
    u_exec.pulse(2'h1, 1'b0);
    u_exec.rd(5'h13, got);
    chk("refresh", 24'h000001, got);
    u_exec.pulse(2'h2, 1'b1);
    settle;
    chk("pc_addr back", 24'h340000, pc_addr_q);
    chk("sp_addr back", 24'hABCDEF, sp_addr_q);
    u_exec.wr_rd(5'h19, 24'h654321, got);
    chk("pair1 back to back", 24'h654321, got);
    @(negedge ref_clk);
    chk("rdata idle", 24'h000000, reg_rdata_q);
    // Mid-run reset brings pointers, page base and flags back to zero
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("sp_addr in reset", 24'h000000, sp_addr_q);
    chk("flags in reset 2", 24'h000000, {20'h0, long_mode_q, interrupt_enable_flag_two_q, interrupt_enable_flag_one_q, mixed_mode_q});
    @(posedge ref_clk);
    reset <= 1'b0;
    u_exec.rd(5'h12, got);
    chk("page base after reset", 24'h000000, got);
    results;
  end
endmodule : test_cpu_register_file_dual_mode
`default_nettype wire
